//--- lps_port_set.sv
// Register port, memory manager port and key export port of the lifecycle manager.
//
// Summary of operation
// [R1] 15-bit register address, low two bits ignored.
// [R2] Register wait at most 512 cycles.
// [R3] Memory transfers extend the register wait.
// [R4] Manager port toward the one-time memory.
// [R5] Memory addresses always word aligned.
// [R6] Memory address width is log2 of size.
// [R7] Key export: 10-bit address, 32-bit data.
// [R8] Key data XOR masked on both halves.
// [R9] Mask sideband only when masking enabled.
// [R10] Everything runs on the single core clock.
// [R11] Asynchronous active-low reset idles all ports.
// [R12] Managers follow setup/access, errors fail transfer.
`timescale 1ns/10ps
`default_nettype none
module lps_port_set #(
    parameter int OTP_SIZE_BYTES = lps_pkg::OTP_SIZE_BYTES,
    parameter bit key_mask_disable_param = 1'b0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [lps_pkg::SUB_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lps_pkg::APB_DATA_W-1:0] pwdata,
    output logic pready,
    output logic [lps_pkg::APB_DATA_W-1:0] prdata,
    output logic pslverr,
    output logic reg_req,
    output logic reg_write,
    output logic [lps_pkg::SUB_IDX_W-1:0] reg_index,
    output logic [lps_pkg::APB_DATA_W-1:0] reg_wdata,
    input wire logic reg_done,
    input wire logic [lps_pkg::APB_DATA_W-1:0] reg_rdata,
    input wire logic reg_err,
    input wire logic otp_cmd_valid,
    input wire logic otp_cmd_write,
    input wire logic [$clog2(OTP_SIZE_BYTES)-1:0] otp_cmd_addr,
    input wire logic [lps_pkg::APB_DATA_W-1:0] otp_cmd_wdata,
    output logic otp_cmd_ready,
    output logic otp_resp_valid,
    output logic [lps_pkg::APB_DATA_W-1:0] otp_resp_rdata,
    output logic otp_resp_err,
    output logic [$clog2(OTP_SIZE_BYTES)-1:0] otp_paddr,
    output logic otp_psel,
    output logic otp_penable,
    output logic otp_pwrite,
    output logic [lps_pkg::APB_DATA_W-1:0] otp_pwdata,
    input wire logic otp_pready,
    input wire logic [lps_pkg::APB_DATA_W-1:0] otp_prdata,
    input wire logic otp_pslverr,
    input wire logic key_cmd_valid,
    input wire logic [lps_pkg::KEY_ADDR_W-1:0] key_cmd_addr,
    input wire logic [lps_pkg::APB_DATA_W-1:0] key_cmd_wdata,
    input wire logic [lps_pkg::KEY_MASK_W-1:0] key_cmd_mask,
    output logic key_cmd_ready,
    output logic key_resp_valid,
    output logic key_resp_err,
    output logic [lps_pkg::KEY_ADDR_W-1:0] key_export_address,
    output logic key_psel,
    output logic key_penable,
    output logic key_pwrite,
    output logic [lps_pkg::APB_DATA_W-1:0] key_export_write_data,
    output logic [lps_pkg::KEY_MASK_W-1:0] key_export_xor_mask,
    input wire logic key_pready,
    input wire logic [lps_pkg::APB_DATA_W-1:0] key_prdata,
    input wire logic key_pslverr
);
    localparam int OTP_ADDR_W = $clog2(OTP_SIZE_BYTES); // R6

    typedef enum logic [1:0] {LPS_SUB_IDLE, LPS_SUB_WAIT, LPS_SUB_RESP} lps_sub_phase_type;
    typedef struct packed {
        lps_sub_phase_type phase;
        logic [lps_pkg::SUB_CNT_W-1:0] cnt;
        logic pready;
        logic [lps_pkg::APB_DATA_W-1:0] prdata;
        logic pslverr;
        logic req;
        logic write;
        logic [lps_pkg::SUB_IDX_W-1:0] index;
        logic [lps_pkg::APB_DATA_W-1:0] wdata;
        logic [lps_pkg::KEY_MASK_W-1:0] key_mask;
        logic [lps_pkg::APB_DATA_W-1:0] key_plain;
    } lps_top_state_type;

    lps_top_state_type st_reg;
    lps_top_state_type st_next;
    logic [lps_pkg::KEY_MASK_W-1:0] mask_eff;
    logic [lps_pkg::APB_DATA_W-1:0] key_masked;
    logic key_take;

    // ------------------------------------------------------------
    // Key masking
    // ------------------------------------------------------------
    // With masking disabled the sideband is held at zero, which leaves the data in clear.
    assign mask_eff = key_mask_disable_param ? lps_pkg::MASK_RST : key_cmd_mask; // R9
    assign key_masked = key_cmd_wdata ^ {mask_eff, mask_eff}; // R8
    assign key_take = key_cmd_valid && key_cmd_ready;

    // ------------------------------------------------------------
    // Register port state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.req = 1'b0;
        if (key_take)
        begin
            st_next.key_mask = mask_eff; // R8
            st_next.key_plain = key_cmd_wdata;
        end
        case (st_reg.phase)
            LPS_SUB_IDLE:
            begin
                st_next.pready = 1'b0;
                if (psel && !penable)
                begin
                    st_next.req = 1'b1;
                    st_next.write = pwrite;
                    st_next.index = paddr[lps_pkg::SUB_ADDR_W-1:lps_pkg::WORD_LSB]; // R1
                    st_next.wdata = pwdata;
                    st_next.cnt = lps_pkg::SUB_CNT_RST;
                    st_next.phase = LPS_SUB_WAIT;
                end
            end
            LPS_SUB_WAIT:
            begin
                if (reg_done)
                begin
                    st_next.pready = 1'b1;
                    st_next.prdata = st_reg.write ? lps_pkg::DATA_RST : reg_rdata;
                    st_next.pslverr = reg_err;
                    st_next.phase = LPS_SUB_RESP;
                end
                else if (!otp_psel) // R3
                begin
                    // The wait budget is spent only while the memory port is quiet.
                    if (st_reg.cnt == lps_pkg::SUB_CNT_LAST) // R2
                    begin
                        st_next.pready = 1'b1;
                        st_next.prdata = lps_pkg::DATA_RST;
                        st_next.pslverr = 1'b1;
                        st_next.phase = LPS_SUB_RESP;
                    end
                    else
                    begin
                        st_next.cnt = st_reg.cnt + 10'h001;
                    end
                end
            end
            LPS_SUB_RESP:
            begin
                st_next.pready = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.phase = LPS_SUB_IDLE;
            end
            default:
            begin
                st_next.phase = LPS_SUB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0; // R11
        end
        else
        begin
            st_reg <= st_next; // R10
        end
    end

    assign pready = st_reg.pready;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign reg_req = st_reg.req;
    assign reg_write = st_reg.write;
    assign reg_index = st_reg.index;
    assign reg_wdata = st_reg.wdata;
    assign key_export_xor_mask = st_reg.key_mask;

    // ------------------------------------------------------------
    // Manager ports
    // ------------------------------------------------------------
    lps_apb_manager #(.ADDR_W(OTP_ADDR_W)) u_otp_mgr ( // R4
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cmd_valid(otp_cmd_valid),
        .cmd_write(otp_cmd_write),
        .cmd_addr(otp_cmd_addr),
        .cmd_wdata(otp_cmd_wdata),
        .cmd_ready(otp_cmd_ready),
        .resp_valid(otp_resp_valid),
        .resp_rdata(otp_resp_rdata),
        .resp_err(otp_resp_err),
        .psel(otp_psel),
        .penable(otp_penable),
        .pwrite(otp_pwrite),
        .paddr(otp_paddr),
        .pwdata(otp_pwdata),
        .pready(otp_pready),
        .prdata(otp_prdata),
        .pslverr(otp_pslverr)
    );

    // Key export is write only; read data from the receiver is not used.
    lps_apb_manager #(.ADDR_W(lps_pkg::KEY_ADDR_W)) u_key_mgr ( // R7
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cmd_valid(key_cmd_valid),
        .cmd_write(1'b1),
        .cmd_addr(key_cmd_addr),
        .cmd_wdata(key_masked),
        .cmd_ready(key_cmd_ready),
        .resp_valid(key_resp_valid),
        .resp_rdata(),
        .resp_err(key_resp_err),
        .psel(key_psel),
        .penable(key_penable),
        .pwrite(key_pwrite),
        .paddr(key_export_address),
        .pwdata(key_export_write_data),
        .pready(key_pready),
        .prdata(key_prdata),
        .pslverr(key_pslverr)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking top_cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sub_forward_a: assert property (st_reg.phase == LPS_SUB_IDLE && psel && !penable |=> // R1
        reg_req && reg_index == $past(paddr[14:2]) && reg_write == $past(pwrite))
        else $error("register request not forwarded");
    sub_wait_cap_a: assert property (st_reg.phase == LPS_SUB_WAIT && !reg_done && // R2
        !otp_psel && st_reg.cnt == lps_pkg::SUB_CNT_LAST |=> pready && pslverr)
        else $error("wait limit not enforced");
    sub_cnt_range_a: assert property (st_reg.cnt <= lps_pkg::SUB_CNT_LAST) // R2
        else $error("wait counter out of range");
    otp_extend_a: assert property (st_reg.phase == LPS_SUB_WAIT && otp_psel && !reg_done |=> // R3
        $stable(st_reg.cnt) && !pready)
        else $error("wait not extended during memory transfer");
    sub_done_a: assert property (st_reg.phase == LPS_SUB_WAIT && reg_done |=> // R2
        pready ##1 !pready)
        else $error("register answer not one cycle");
    key_xor_a: assert property (key_psel |-> // R8
        (key_export_write_data ^ {key_export_xor_mask, key_export_xor_mask}) == st_reg.key_plain)
        else $error("key data not masked by sideband");
    key_mask_off_a: assert property (key_mask_disable_param |-> key_export_xor_mask == '0) // R9
        else $error("mask present while masking disabled");
    key_write_a: assert property (key_psel |-> key_pwrite) // R7
        else $error("key export not a write");

    sub_timeout_cov: cover property (st_reg.phase == LPS_SUB_WAIT ##1 pready && pslverr);
    sub_otp_cov: cover property (st_reg.phase == LPS_SUB_WAIT && otp_psel);
    key_xfer_cov: cover property (key_psel && key_penable && key_pready);
    sub_b2b_cov: cover property (st_reg.phase == LPS_SUB_RESP ##1 psel && !penable);
endmodule
`default_nettype wire

//--- lps_pkg.sv
// Shared constants for the lifecycle bus port set.
package lps_pkg;
    localparam int APB_DATA_W = 32;
    localparam int SUB_ADDR_W = 15;
    localparam int WORD_LSB = 2;
    localparam int SUB_IDX_W = SUB_ADDR_W - WORD_LSB;
    localparam int SUB_WAIT_MAX = 512;
    localparam int SUB_CNT_W = 10;
    localparam int OTP_SIZE_BYTES = 16384;
    localparam int KEY_ADDR_W = 10;
    localparam int KEY_MASK_W = 16;
    localparam logic [SUB_CNT_W-1:0] SUB_CNT_LAST = 10'h1ff;
    localparam logic [SUB_CNT_W-1:0] SUB_CNT_RST = 10'h000;
    localparam logic [APB_DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [KEY_MASK_W-1:0] MASK_RST = 16'h0000;
    localparam logic [1:0] ALIGN_ZERO = 2'h0;
endpackage

//--- lps_apb_manager.sv
// Generic APB3 manager used for the memory port and the key export port.
`timescale 1ns/10ps
`default_nettype none
module lps_apb_manager #(
    parameter int ADDR_W = 14
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [lps_pkg::APB_DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [lps_pkg::APB_DATA_W-1:0] resp_rdata,
    output logic resp_err,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [lps_pkg::APB_DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic [lps_pkg::APB_DATA_W-1:0] prdata,
    input wire logic pslverr
);
    typedef enum logic [1:0] {LPS_MGR_IDLE, LPS_MGR_SETUP, LPS_MGR_ACCESS} lps_mgr_phase_type;
    typedef struct packed {
        lps_mgr_phase_type phase;
        logic cmd_ready;
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [lps_pkg::APB_DATA_W-1:0] pwdata;
        logic resp_valid;
        logic [lps_pkg::APB_DATA_W-1:0] resp_rdata;
        logic resp_err;
    } lps_mgr_state_type;

    lps_mgr_state_type st_reg;
    lps_mgr_state_type st_next;

    // ------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.resp_valid = 1'b0;
        case (st_reg.phase)
            LPS_MGR_IDLE:
            begin
                st_next.cmd_ready = 1'b1;
                if (st_reg.cmd_ready && cmd_valid)
                begin
                    st_next.cmd_ready = 1'b0;
                    st_next.psel = 1'b1; // R12
                    st_next.pwrite = cmd_write;
                    st_next.paddr = {cmd_addr[ADDR_W-1:lps_pkg::WORD_LSB], lps_pkg::ALIGN_ZERO}; // R5
                    st_next.pwdata = cmd_wdata;
                    st_next.phase = LPS_MGR_SETUP;
                end
            end
            LPS_MGR_SETUP:
            begin
                st_next.penable = 1'b1; // R12
                st_next.phase = LPS_MGR_ACCESS;
            end
            LPS_MGR_ACCESS:
            begin
                // Address and data stay put until the far end answers.
                if (pready) // R12
                begin
                    st_next.psel = 1'b0;
                    st_next.penable = 1'b0;
                    st_next.resp_valid = 1'b1;
                    st_next.resp_rdata = st_reg.pwrite ? lps_pkg::DATA_RST : prdata;
                    st_next.resp_err = pslverr; // R12
                    st_next.cmd_ready = 1'b1;
                    st_next.phase = LPS_MGR_IDLE;
                end
            end
            default:
            begin
                st_next.phase = LPS_MGR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '0; // R11
        end
        else
        begin
            st_reg <= st_next; // R10
        end
    end

    assign cmd_ready = st_reg.cmd_ready;
    assign resp_valid = st_reg.resp_valid;
    assign resp_rdata = st_reg.resp_rdata;
    assign resp_err = st_reg.resp_err;
    assign psel = st_reg.psel;
    assign penable = st_reg.penable;
    assign pwrite = st_reg.pwrite;
    assign paddr = st_reg.paddr;
    assign pwdata = st_reg.pwdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking mgr_cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    mgr_setup_access_a: assert property (psel && !penable |=> psel && penable) // R12
        else $error("setup phase not followed by access phase");
    mgr_hold_stable_a: assert property (psel && penable && !pready |=> // R12
        $stable(paddr) && $stable(pwdata) && $stable(pwrite) && psel)
        else $error("manager outputs changed during wait");
    mgr_addr_align_a: assert property (psel |-> paddr[1:0] == lps_pkg::ALIGN_ZERO) // R5
        else $error("manager address not word aligned");
    mgr_err_pass_a: assert property (psel && penable && pready |=> // R12
        resp_valid && resp_err == $past(pslverr) && !psel)
        else $error("response not reported after ready");
    mgr_err_cov: cover property (psel && penable && pready && pslverr);
endmodule
`default_nettype wire

//--- lps_far_model.sv
// Far-end APB3 subordinate model for the memory port and the key receiver port.
`timescale 1ns/10ps
`default_nettype none
module lps_far_model #(
    parameter int AW = 14
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [AW-1:0] paddr,
    input wire logic [7:0] wait_n,
    input wire logic fail,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    logic [7:0] cnt_reg;
    logic [31:0] noise_reg;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= 8'h00;
            noise_reg <= 32'h0000_0001;
        end
        else
        begin
            noise_reg <= {noise_reg[30:0], noise_reg[31] ^ noise_reg[21] ^ noise_reg[0]};
            cnt_reg <= (psel && penable && !pready) ? cnt_reg + 8'h01 : 8'h00;
        end
    end

    // Outside the ready cycle the data and error lines carry noise, so a manager
    // that samples them early sees garbage rather than a lucky zero.
    assign pready = psel && penable && (cnt_reg == wait_n);
    assign prdata = pready ? (32'h3c5a_0000 ^ 32'(paddr)) : noise_reg;
    assign pslverr = pready ? fail : noise_reg[3];
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the lifecycle bus port set.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic reg_done = 1'b0, reg_err = 1'b0, core_err = 1'b0, otp_fail = 1'b0, key_fail = 1'b0;
    logic otp_cmd_valid = 1'b0, otp_cmd_write = 1'b0, key_cmd_valid = 1'b0;
    logic [14:0] paddr = 15'h0000;
    logic [13:0] otp_cmd_addr = 14'h0000, otp_paddr;
    logic [9:0] key_cmd_addr = 10'h000, key_export_address;
    logic [15:0] key_cmd_mask = 16'h0000, key_export_xor_mask;
    logic [7:0] otp_wait = 8'h00, key_wait = 8'h00;
    logic [31:0] pwdata = 32'h0, reg_rdata = 32'h0, otp_cmd_wdata = 32'h0, key_cmd_wdata = 32'h0;
    logic [31:0] prdata, reg_wdata, otp_resp_rdata, otp_pwdata, otp_prdata, key_prdata;
    logic [31:0] key_export_write_data, clear_wdata;
    logic [15:0] clear_mask;
    logic [31:0] rnd [0:199];
    logic [12:0] reg_index;
    logic pready, pslverr, reg_req, reg_write, otp_cmd_ready, otp_resp_valid, otp_resp_err;
    logic otp_psel, otp_penable, otp_pwrite, otp_pready, otp_pslverr, key_cmd_ready;
    logic key_resp_valid, key_resp_err, key_psel, key_penable, key_pwrite, key_pready, key_pslverr;
    int n_fail = 0, total_checks = 0, cycles = 0, seed = 41098, core_delay = -1, core_cnt = -1;

    lps_port_set dut (.clk_sys, .arst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
        .prdata, .pslverr, .reg_req, .reg_write, .reg_index, .reg_wdata, .reg_done, .reg_rdata,
        .reg_err, .otp_cmd_valid, .otp_cmd_write, .otp_cmd_addr, .otp_cmd_wdata, .otp_cmd_ready,
        .otp_resp_valid, .otp_resp_rdata, .otp_resp_err, .otp_paddr, .otp_psel, .otp_penable,
        .otp_pwrite, .otp_pwdata, .otp_pready, .otp_prdata, .otp_pslverr, .key_cmd_valid,
        .key_cmd_addr, .key_cmd_wdata, .key_cmd_mask, .key_cmd_ready, .key_resp_valid,
        .key_resp_err, .key_export_address, .key_psel, .key_penable, .key_pwrite,
        .key_export_write_data, .key_export_xor_mask, .key_pready, .key_prdata, .key_pslverr);
    lps_far_model #(.AW(14)) otp_far (.clk_sys, .arst_n, .psel(otp_psel), .penable(otp_penable),
        .paddr(otp_paddr), .wait_n(otp_wait), .fail(otp_fail), .pready(otp_pready),
        .prdata(otp_prdata), .pslverr(otp_pslverr));
    lps_far_model #(.AW(10)) key_far (.clk_sys, .arst_n, .psel(key_psel), .penable(key_penable),
        .paddr(key_export_address), .wait_n(key_wait), .fail(key_fail), .pready(key_pready),
        .prdata(key_prdata), .pslverr(key_pslverr));
    // A copy built with masking off sees the same traffic; its key data must leave in clear.
    lps_port_set #(.key_mask_disable_param(1'b1)) dut_clear (.clk_sys, .arst_n, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pready(), .prdata(), .pslverr(), .reg_req(), .reg_write(),
        .reg_index(), .reg_wdata(), .reg_done, .reg_rdata, .reg_err, .otp_cmd_valid,
        .otp_cmd_write, .otp_cmd_addr, .otp_cmd_wdata, .otp_cmd_ready(), .otp_resp_valid(),
        .otp_resp_rdata(), .otp_resp_err(), .otp_paddr(), .otp_psel(), .otp_penable(),
        .otp_pwrite(), .otp_pwdata(), .otp_pready, .otp_prdata, .otp_pslverr, .key_cmd_valid,
        .key_cmd_addr, .key_cmd_wdata, .key_cmd_mask, .key_cmd_ready(), .key_resp_valid(),
        .key_resp_err(), .key_export_address(), .key_psel(), .key_penable(), .key_pwrite(),
        .key_export_write_data(clear_wdata), .key_export_xor_mask(clear_mask), .key_pready,
        .key_prdata, .key_pslverr);

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Core register responder and shared checking tasks
    // ------------------------------------------------------------
    always @(negedge clk_sys)
    begin
        reg_done <= 1'b0;
        reg_err <= core_err;
        reg_rdata <= ~reg_rdata;
        if (reg_req === 1'b1)
            core_cnt = core_delay;
        if (core_cnt == 0)
        begin
            reg_done <= 1'b1;
            reg_rdata <= 32'hc0de_0000 ^ {19'h0, reg_index};
        end
        if (core_cnt >= 0)
            core_cnt = core_cnt - 1;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // A negative delay means the core never answers, which forces the wait limit.
    task automatic reg_xfer(input logic [14:0] a, input logic w, input logic [31:0] d,
        input int dly, input logic e);
        int n;
        int o;
        core_delay = dly;
        core_err = e;
        paddr = a;
        pwrite = w;
        pwdata = d;
        psel = 1'b1;
        penable = 1'b0;
        @(negedge clk_sys);
        penable = 1'b1;
        n = 0;
        o = 0;
        while (pready !== 1'b1 && n < 1200)
        begin
            if (reg_req === 1'b1)
            begin
                check("reg index", {19'h0, a[14:2]}, {19'h0, reg_index});
                check("reg write", {31'h0, w}, {31'h0, reg_write});
                check("reg wdata", d, reg_wdata);
            end
            @(negedge clk_sys);
            n++;
            o += (otp_psel === 1'b1);
        end
        if (dly < 0)
        begin
            check("timeout err", 32'h1, {31'h0, pslverr});
            check("wait limit", 32'h1, {31'h0, (n - o >= 511) && (n - o <= 516)});
        end
        else
        begin
            check("reg err", {31'h0, e}, {31'h0, pslverr});
            check("reg wait", 32'h1, {31'h0, n <= dly + 4});
            if (!e)
                check("reg rdata", w ? 32'h0 : 32'hc0de_0000 ^ {19'h0, a[14:2]}, prdata);
        end
        @(negedge clk_sys);
    endtask

    task automatic mgr_xfer(input logic k, input logic [13:0] a, input logic w,
        input logic [31:0] d, input logic [15:0] m, input logic [7:0] wt, input logic f);
        int n;
        logic [13:0] al;
        al = {a[13:2], 2'h0};
        n = 0;
        while ((k ? key_cmd_ready : otp_cmd_ready) !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (k)
        begin
            key_cmd_addr = a[9:0];
            key_cmd_wdata = d;
            key_cmd_mask = m;
            key_wait = wt;
            key_fail = f;
            key_cmd_valid = 1'b1;
        end
        else
        begin
            otp_cmd_addr = a;
            otp_cmd_write = w;
            otp_cmd_wdata = d;
            otp_wait = wt;
            otp_fail = f;
            otp_cmd_valid = 1'b1;
        end
        @(negedge clk_sys);
        if (k)
            key_cmd_valid = 1'b0;
        else
            otp_cmd_valid = 1'b0;
        n = 0;
        while ((k ? key_resp_valid : otp_resp_valid) !== 1'b1 && n < 300)
        begin
            if (k && key_psel === 1'b1)
            begin
                check("key addr", {22'h0, al[9:0]}, {22'h0, key_export_address});
                check("key masked", d ^ {m, m}, key_export_write_data);
                check("key unmasked", d, key_export_write_data ^ {2{key_export_xor_mask}});
                check("key write", 32'h1, {31'h0, key_pwrite});
                check("key clear", d, clear_wdata);
                check("clear mask", 32'h0, {16'h0, clear_mask});
            end
            if (!k && otp_psel === 1'b1)
            begin
                check("otp addr", {18'h0, al}, {18'h0, otp_paddr});
                check("otp write", {31'h0, w}, {31'h0, otp_pwrite});
                if (w)
                    check("otp wdata", d, otp_pwdata);
            end
            @(negedge clk_sys);
            n++;
        end
        check("resp err", {31'h0, f}, {31'h0, k ? key_resp_err : otp_resp_err});
        check("resp time", 32'h1, {31'h0, n <= wt + 4});
        if (!k && !f)
            check("otp rdata", w ? 32'h0 : 32'h3c5a_0000 ^ {18'h0, al}, otp_resp_rdata);
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            close_out();
        end
    end

    initial
    begin
        for (int i = 0; i < 200; i++)
            rnd[i] = $random(seed);
        repeat (3) @(negedge clk_sys);
        check("reset idle", 32'h0, {21'h0, pready, pslverr, reg_req, otp_psel, otp_penable,
            key_psel, key_penable, otp_cmd_ready, key_cmd_ready, otp_resp_valid,
            key_resp_valid});
        check("reset addr", 32'h0, {8'h0, otp_paddr, key_export_address});
        check("otp addr width", 32'h0000_000e, $bits(dut.otp_paddr));
        repeat (9) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        // The long memory access overlaps the register timeout to show the wait stretching.
        fork
            begin
                reg_xfer(15'h0004, 1'b1, 32'hffff_ffff, -1, 1'b0);
                reg_xfer(15'h7fff, 1'b0, 32'h0, 0, 1'b0);
                for (int i = 0; i < 30; i++)
                    reg_xfer(rnd[i][14:0], rnd[i][15], rnd[i + 40], rnd[i][19:16],
                        rnd[i][20] & rnd[i][21]);
                psel = 1'b0;
                penable = 1'b0;
            end
            begin
                mgr_xfer(1'b0, 14'h3fff, 1'b0, 32'h0, 16'h0, 8'h3c, 1'b0);
                for (int i = 80; i < 110; i++)
                    mgr_xfer(1'b0, rnd[i][13:0], rnd[i][14], rnd[i + 60], 16'h0,
                        {5'h0, rnd[i][17:15]}, rnd[i][20:18] == 3'h0);
            end
            begin
                mgr_xfer(1'b1, 14'h03ff, 1'b1, 32'h0, 16'hffff, 8'h00, 1'b0);
                for (int i = 110; i < 140; i++)
                    mgr_xfer(1'b1, rnd[i][13:0], 1'b1, rnd[i + 60], rnd[i][31:16],
                        {5'h0, rnd[i][2:0]}, rnd[i][5:3] == 3'h0);
            end
        join
        // A reset in mid-transfer must idle the memory port at once and let it recover.
        otp_cmd_valid = 1'b1;
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b0;
        #1;
        check("mid reset", 32'h0, {28'h0, otp_psel, otp_penable, otp_cmd_ready,
            otp_pwrite});
        @(negedge clk_sys);
        otp_cmd_valid = 1'b0;
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("mid recover", 32'h1, {31'h0, otp_cmd_ready});
        repeat (3) @(negedge clk_sys);
        close_out();
    end
endmodule
`default_nettype wire
